// >>> rtl/unis_pkg.sv
// Shared constants and types for the nine-bit UART with pulse shaper.
// Assumes one 10 MHz clock and special function register style access.
package unis_pkg;
  // Special function register addresses
  localparam logic [7:0] UNIS_CTRL_ADDR = 8'hC0;
  localparam logic [7:0] UNIS_SERIAL_BUFFER_ADDR = 8'hC1;
  localparam logic [7:0] UNIS_IRCTL_ADDR = 8'hCE;
  localparam logic [7:0] UNIS_CTRL_RST = 8'h00;
  localparam logic [7:0] UNIS_IRCTL_RST = 8'h0F;
  // Fixed rate: 16x tick every 2 or 4 clocks (bit = 1/32 or 1/64 clock)
  localparam logic [1:0] UNIS_DIV_FAST = 2'h1;
  localparam logic [1:0] UNIS_DIV_SLOW = 2'h3;
  // Divide-by-16 states
  localparam logic [3:0] UNIS_S_SAMP1 = 4'h7;
  localparam logic [3:0] UNIS_S_SAMP2 = 4'h8;
  localparam logic [3:0] UNIS_S_SAMP3 = 4'h9;
  localparam logic [3:0] UNIS_S_LAST = 4'hF;
  localparam logic [8:0] UNIS_RX_FILL = 9'h1FF;
  localparam logic [7:0] UNIS_TX_LAST = 8'h01;
  // Shaper pulse length in units, receive stretch in 16x ticks
  localparam logic [4:0] UNIS_PULSE_UNITS = 5'h03;
  localparam logic [4:0] UNIS_STRETCH = 5'h10;
  localparam logic [4:0] UNIS_DIV_ONE = 5'h01;

  typedef struct packed {
    logic var_rate;
    logic rate_dbl;
    logic multiproc_enable;
    logic rsvd;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } unis_ctrl_t;

  typedef struct packed {
    logic rsvd;
    logic infrared_enable;
    logic width_mode_sel;
    logic [4:0] ref_clock_divisor;
  } unis_irctl_t;

  typedef enum {UNIS_TX_IDLE, UNIS_TX_PEND, UNIS_TX_START,
    UNIS_TX_DATA} unis_tx_state_t;
  typedef enum {UNIS_RX_IDLE, UNIS_RX_BITS, UNIS_RX_STOP} unis_rx_state_t;
endpackage : unis_pkg

// >>> rtl/unis_shaper.sv
// Infrared pulse shaper between the channel-1 UART and its pins.
// Assumes rx_sync is already synchronised and tick16 is a 16x bit tick.
`timescale 1ns/1ps
`default_nettype none
module unis_shaper (
  input wire logic clock,
  input wire logic arst_n,
  input wire unis_pkg::unis_irctl_t cfg,
  input wire logic tick16,
  input wire logic tx_data,
  input wire logic tx_strobe,
  input wire logic rx_sync,
  output logic tx_pin,
  output logic rx_data
);
  logic [4:0] ref_cnt_reg;
  logic [4:0] pulse_cnt_reg;
  logic [4:0] str_cnt_reg;
  logic rx_prev_reg;
  logic tick_dly_reg;
  logic ref_en;
  logic unit_en;
  logic pulse_go;

  assign pulse_go = cfg.infrared_enable & tx_strobe & ~tx_data;
  assign ref_en =
    (ref_cnt_reg + unis_pkg::UNIS_DIV_ONE) >= cfg.ref_clock_divisor;
  // Delayed tick keeps three ticks measured from the pin's own bit start
  assign unit_en = cfg.width_mode_sel ? tick_dly_reg : ref_en;

  // Tick delayed by the pin flop, so pulse length is not cut short
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_dly_reg <= 1'b0;
    end else begin
      tick_dly_reg <= tick16;
    end
  end

  // reference clock divider, restarted at each pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt_reg <= 5'h00;
    end else if (pulse_go || ref_en) begin
      ref_cnt_reg <= 5'h00;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + unis_pkg::UNIS_DIV_ONE;
    end
  end

  // zero bit becomes a short high pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pulse_cnt_reg <= 5'h00;
      tx_pin <= 1'b1;
    end else if (!cfg.infrared_enable) begin
      pulse_cnt_reg <= 5'h00;
      tx_pin <= tx_data; // bypass
    end else if (pulse_go) begin
      pulse_cnt_reg <= unis_pkg::UNIS_PULSE_UNITS;
      tx_pin <= 1'b1;
    end else if (unit_en && pulse_cnt_reg != 5'h00) begin
      pulse_cnt_reg <= pulse_cnt_reg - unis_pkg::UNIS_DIV_ONE;
      tx_pin <= (pulse_cnt_reg != unis_pkg::UNIS_DIV_ONE);
    end else if (pulse_cnt_reg == 5'h00) begin
      tx_pin <= 1'b0;
    end
  end

  // stretch received pulse to a full low bit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_prev_reg <= 1'b1; // Matches idle line, no false edge
      str_cnt_reg <= 5'h00;
      rx_data <= 1'b1;
    end else begin
      rx_prev_reg <= rx_sync;
      if (!cfg.infrared_enable) begin
        str_cnt_reg <= 5'h00;
        rx_data <= rx_sync;
      end else if (rx_sync && !rx_prev_reg) begin
        str_cnt_reg <= unis_pkg::UNIS_STRETCH;
        rx_data <= 1'b0;
      end else if (tick16 && str_cnt_reg != 5'h00) begin
        str_cnt_reg <= str_cnt_reg - unis_pkg::UNIS_DIV_ONE;
        rx_data <= (str_cnt_reg == unis_pkg::UNIS_DIV_ONE);
      end
    end
  end

  AST_SHP_BYPASS: assert property (@(posedge clock) disable iff (!arst_n)
    (!cfg.infrared_enable && $past(!cfg.infrared_enable))
    |-> tx_pin == $past(tx_data))
    else $error("bypass tx pin differs");
  // stretched pulse gives a low level
  AST_SHP_STRETCH: assert property (@(posedge clock) disable iff (!arst_n)
    (cfg.infrared_enable && rx_sync && !rx_prev_reg) |=> !rx_data[*2])
    else $error("received pulse not stretched");
  AST_SHP_ONE: assert property (@(posedge clock) disable iff (!arst_n)
    (cfg.infrared_enable && tx_strobe && tx_data && pulse_cnt_reg == 5'h00)
    |=> !tx_pin)
    else $error("pulse sent for a one bit");
  COV_SHP_PULSE: cover property (@(posedge clock) disable iff (!arst_n)
    pulse_go ##1 tx_pin[*3]);
endmodule : unis_shaper
`default_nettype wire

// >>> rtl/unis_uart.sv
// Nine-bit UART channel 1 with infrared shaper and its registers.
// Assumes a synchronous register port and a timer rollover pulse.
`timescale 1ns/1ps
`default_nettype none
module unis_uart (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic timer_rollover,
  input wire logic ch1_rx_pin,
  output logic ch1_tx_pin
);
  unis_pkg::unis_ctrl_t ctrl_reg;
  unis_pkg::unis_irctl_t irctl_reg;
  unis_pkg::unis_tx_state_t tx_state_reg;
  unis_pkg::unis_rx_state_t rx_state_reg;
  logic [1:0] pre_cnt_reg;
  logic tick_reg;
  logic [3:0] tx_div_reg;
  logic [8:0] tsr_reg;
  logic tx_first_reg;
  logic tx_line_reg;
  logic tx_strobe_reg;
  logic [3:0] rx_div_reg;
  logic [8:0] rsr_reg;
  logic rx_first_reg;
  logic s7_reg;
  logic s8_reg;
  logic rx_prev_reg;
  logic [7:0] rx_buf_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic rx_line;
  logic tx_roll;
  logic tx_fin;
  logic serial_buffer_wr;
  logic maj;
  logic bit_pt;
  logic rx_load;
  logic accept;
  logic [7:0] rx_byte;

  assign serial_buffer_wr = sfr_wr && sfr_addr == unis_pkg::UNIS_SERIAL_BUFFER_ADDR;
  assign tx_roll = tick_reg && tx_div_reg == unis_pkg::UNIS_S_LAST;
  assign tx_fin = tx_state_reg == unis_pkg::UNIS_TX_DATA && tx_roll
    && !tx_first_reg && tsr_reg[8:1] == unis_pkg::UNIS_TX_LAST;
  assign maj = (s7_reg & s8_reg) | (s7_reg & rx_line) | (s8_reg & rx_line);
  assign bit_pt = tick_reg && rx_div_reg == unis_pkg::UNIS_S_SAMP3;
  assign rx_load = rx_state_reg == unis_pkg::UNIS_RX_BITS && bit_pt
    && !rx_first_reg && !rsr_reg[8];
  assign accept = rx_load && !ctrl_reg.rx_done_flag
    && (!ctrl_reg.multiproc_enable || maj);
  assign rx_byte = {<<{rsr_reg[7:0]}};

  // 16x tick from clock or timer rollovers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_reg <= 2'h0;
      tick_reg <= 1'b0;
    end else if (ctrl_reg.var_rate) begin
      if (timer_rollover) begin
        pre_cnt_reg <= pre_cnt_reg ^ 2'h1;
      end
      tick_reg <= timer_rollover && (ctrl_reg.rate_dbl || pre_cnt_reg[0]);
    end else if (pre_cnt_reg >= (ctrl_reg.rate_dbl ?
        unis_pkg::UNIS_DIV_FAST : unis_pkg::UNIS_DIV_SLOW)) begin
      pre_cnt_reg <= 2'h0;
      tick_reg <= 1'b1;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 2'h1;
      tick_reg <= 1'b0;
    end
  end

  // Free running transmit divide-by-16
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_div_reg <= 4'h0;
    end else if (tick_reg) begin
      tx_div_reg <= tx_div_reg + 4'h1;
    end
  end

  // Transmit control and shift register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_reg <= unis_pkg::UNIS_TX_IDLE;
      tsr_reg <= 9'h000;
      tx_first_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      tx_strobe_reg <= 1'b0;
    end else begin
      tx_strobe_reg <= 1'b0;
      if (serial_buffer_wr) begin
        tsr_reg <= {ctrl_reg.tx_ninth_bit, sfr_wdata};
        tx_state_reg <= unis_pkg::UNIS_TX_PEND;
        tx_line_reg <= 1'b1;
      end else begin
        case (tx_state_reg)
          unis_pkg::UNIS_TX_IDLE: begin
            tx_line_reg <= 1'b1;
          end
          unis_pkg::UNIS_TX_PEND: begin
            if (tx_roll) begin
              tx_state_reg <= unis_pkg::UNIS_TX_START;
              tx_line_reg <= 1'b0;
              tx_strobe_reg <= 1'b1;
            end
          end
          unis_pkg::UNIS_TX_START: begin
            if (tx_roll) begin
              tx_state_reg <= unis_pkg::UNIS_TX_DATA;
              tx_line_reg <= tsr_reg[0];
              tx_strobe_reg <= 1'b1;
              tx_first_reg <= 1'b1;
            end
          end
          unis_pkg::UNIS_TX_DATA: begin
            if (tx_roll) begin
              tsr_reg <= {tx_first_reg, tsr_reg[8:1]};
              tx_line_reg <= tsr_reg[1];
              tx_strobe_reg <= 1'b1;
              tx_first_reg <= 1'b0;
              if (tx_fin) begin
                tx_state_reg <= unis_pkg::UNIS_TX_IDLE;
              end
            end
          end
          default: begin
            tx_state_reg <= unis_pkg::UNIS_TX_IDLE;
          end
        endcase
      end
    end
  end

  // Two-stage synchroniser for the receive pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= ch1_rx_pin;
      sync2_reg <= sync1_reg;
    end
  end

  unis_shaper u_shaper (
    .clock(clock),
    .arst_n(arst_n),
    .cfg(irctl_reg),
    .tick16(tick_reg),
    .tx_data(tx_line_reg),
    .tx_strobe(tx_strobe_reg),
    .rx_sync(sync2_reg),
    .tx_pin(ch1_tx_pin),
    .rx_data(rx_line)
  );

  // Receive control and shift register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_reg <= unis_pkg::UNIS_RX_IDLE;
      rx_div_reg <= 4'h0;
      rsr_reg <= unis_pkg::UNIS_RX_FILL;
      rx_first_reg <= 1'b0;
      s7_reg <= 1'b1;
      s8_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_line;
      case (rx_state_reg)
        unis_pkg::UNIS_RX_IDLE: begin
          if (rx_prev_reg && !rx_line) begin
            rx_div_reg <= 4'h0;
            rsr_reg <= unis_pkg::UNIS_RX_FILL;
            rx_first_reg <= 1'b1;
            rx_state_reg <= unis_pkg::UNIS_RX_BITS;
          end
        end
        unis_pkg::UNIS_RX_BITS: begin
          if (tick_reg) begin
            rx_div_reg <= rx_div_reg + 4'h1;
          end
          if (tick_reg && rx_div_reg == unis_pkg::UNIS_S_SAMP1) begin
            s7_reg <= rx_line;
          end
          if (tick_reg && rx_div_reg == unis_pkg::UNIS_S_SAMP2) begin
            s8_reg <= rx_line;
          end
          if (bit_pt) begin
            rsr_reg <= {rsr_reg[7:0], maj};
            rx_first_reg <= 1'b0;
            if (rx_first_reg && maj) begin
              rx_state_reg <= unis_pkg::UNIS_RX_IDLE;
            end else if (!rx_first_reg && !rsr_reg[8]) begin
              rx_state_reg <= unis_pkg::UNIS_RX_STOP;
            end
          end
        end
        unis_pkg::UNIS_RX_STOP: begin
          if (tick_reg) begin
            rx_div_reg <= rx_div_reg + 4'h1;
          end
          // back to search one bit later
          if (bit_pt) begin
            rx_state_reg <= unis_pkg::UNIS_RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= unis_pkg::UNIS_RX_IDLE;
        end
      endcase
    end
  end

  // receive buffer load on accepted frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_buf_reg <= 8'h00;
    end else if (accept) begin
      rx_buf_reg <= rx_byte;
    end
  end

  // Control register; hardware set wins over clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= unis_pkg::UNIS_CTRL_RST;
    end else begin
      if (sfr_wr && sfr_addr == unis_pkg::UNIS_CTRL_ADDR) begin
        ctrl_reg <= {sfr_wdata[7:6], sfr_wdata[5], 1'b0, sfr_wdata[3],
          ctrl_reg.rx_ninth_bit, sfr_wdata[1:0]};
      end
      if (tx_fin) begin
        ctrl_reg.tx_done_flag <= 1'b1;
      end
      if (accept) begin
        ctrl_reg.rx_done_flag <= 1'b1;
        ctrl_reg.rx_ninth_bit <= maj;
      end
    end
  end

  // shaper control, off with divisor fifteen
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irctl_reg <= unis_pkg::UNIS_IRCTL_RST;
    end else if (sfr_wr && sfr_addr == unis_pkg::UNIS_IRCTL_ADDR) begin
      irctl_reg <= {1'b0, sfr_wdata[6:0]};
    end
  end

  // Registered read data
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      case (sfr_addr)
        unis_pkg::UNIS_CTRL_ADDR: sfr_rdata <= ctrl_reg;
        unis_pkg::UNIS_SERIAL_BUFFER_ADDR: sfr_rdata <= rx_buf_reg;
        unis_pkg::UNIS_IRCTL_ADDR: sfr_rdata <= irctl_reg;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  AST_TX_START: assert property (
    tx_state_reg == unis_pkg::UNIS_TX_PEND && tx_roll && !serial_buffer_wr
    |=> !tx_line_reg && tx_state_reg == unis_pkg::UNIS_TX_START)
    else $error("start bit not driven at rollover");
  AST_TX_LOAD: assert property (
    serial_buffer_wr |=> tsr_reg == {$past(ctrl_reg.tx_ninth_bit), $past(sfr_wdata)}
    && tx_state_reg == unis_pkg::UNIS_TX_PEND)
    else $error("buffer write not loaded");
  AST_TX_STOP_IN: assert property (
    tx_state_reg == unis_pkg::UNIS_TX_DATA && tx_roll && tx_first_reg
    && !serial_buffer_wr |=> tsr_reg[8])
    else $error("stop bit not inserted");
  AST_TX_DONE: assert property (
    tx_fin && !serial_buffer_wr |=> ctrl_reg.tx_done_flag && tx_line_reg
    && tx_state_reg == unis_pkg::UNIS_TX_IDLE)
    else $error("transmit end wrong");
  AST_TX_ALIGN: assert property (
    $rose(tx_strobe_reg) |-> tx_div_reg == 4'h0)
    else $error("bit edge off the counter");
  AST_RX_FILL: assert property (
    rx_state_reg == unis_pkg::UNIS_RX_IDLE && rx_prev_reg && !rx_line
    |=> rsr_reg == unis_pkg::UNIS_RX_FILL && rx_div_reg == 4'h0)
    else $error("receiver not restarted on edge");
  AST_RX_FALSE: assert property (
    rx_state_reg == unis_pkg::UNIS_RX_BITS && bit_pt && rx_first_reg
    && maj |=> rx_state_reg == unis_pkg::UNIS_RX_IDLE)
    else $error("false start accepted");
  AST_RX_DROP: assert property (
    rx_load && !accept |=> $stable(rx_buf_reg))
    else $error("discarded frame loaded");
  AST_RX_ACCEPT: assert property (
    accept |=> ctrl_reg.rx_done_flag && rx_buf_reg == $past(rx_byte)
    && ctrl_reg.rx_ninth_bit == $past(maj))
    else $error("accepted frame not loaded");
  AST_RX_RESUME: assert property (
    rx_load |=> rx_state_reg == unis_pkg::UNIS_RX_STOP ##[1:64]
    rx_state_reg == unis_pkg::UNIS_RX_IDLE)
    else $error("receiver did not resume search");
  COV_TX_FRAME: cover property (tx_fin);
  COV_RX_ACCEPT: cover property (accept);
  COV_RX_FALSE: cover property (rx_state_reg == unis_pkg::UNIS_RX_BITS
    && bit_pt && rx_first_reg && maj);
endmodule : unis_uart
`default_nettype wire

// >>> tb/unis_remote.sv
// Remote UART and infrared transceiver model on the channel-1 pins.
// Assumes the bench clock; the line changes only at falling edges.
`timescale 1ns/1ps
`default_nettype none
module unis_remote (
  input wire logic clock,
  input wire logic line_in,
  output logic line_out
);
  // Plain line idles high
  initial line_out = 1'b1;

  // Idle level: low for infrared, high otherwise
  task automatic idle(input logic level);
    @(negedge clock);
    line_out = level;
  endtask : idle

  // Short low pulse that must not count as a start bit
  task automatic false_start(input int n);
    @(negedge clock);
    line_out = 1'b0;
    repeat (n) @(negedge clock);
    line_out = 1'b1;
  endtask : false_start

  task automatic send(input int bit_clks, input logic ir, input int pulse,
      input logic glitch, input logic [8:0] d);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      for (int c = 0; c < bit_clks; c++) begin
        @(negedge clock);
        if (ir) begin
          line_out = !f[i] && c < pulse;
        end else begin
          line_out = f[i] ^ (glitch && i == 1 && c == bit_clks / 2);
        end
      end
    end
  endtask : send

  // Waits for a start bit, then samples each bit at its middle
  task automatic recv(input int bit_clks, output logic [10:0] f,
      output int lat);
    lat = 0;
    while (line_in !== 1'b0 && lat < 400) begin
      @(negedge clock);
      lat++;
    end
    repeat (bit_clks / 2) @(negedge clock);
    for (int i = 0; i < 11; i++) begin
      f[i] = line_in;
      repeat (bit_clks) @(negedge clock);
    end
  endtask : recv

  task automatic ir_recv(input int span, output int width, output int n);
    logic prev;
    int t;
    width = 0;
    n = 1;
    t = 0;
    while (line_in !== 1'b1 && t < 400) begin
      @(negedge clock);
      t++;
    end
    for (int c = 0; c < span; c++) begin
      if (line_in === 1'b1 && n == 1) width++;
      prev = line_in;
      @(negedge clock);
      if (prev === 1'b0 && line_in === 1'b1) n++;
    end
  endtask : ir_recv
endmodule : unis_remote
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the nine-bit UART with pulse shaper.
// Assumes the remote model on the pins and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock;
  logic arst_n;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic timer_rollover;
  logic ch1_rx_pin;
  logic ch1_tx_pin;
  logic [1:0] tcnt;
  int fails;
  int check_count;

  unis_uart i_unis_uart (.clock(clock), .arst_n(arst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .timer_rollover(timer_rollover),
    .ch1_rx_pin(ch1_rx_pin), .ch1_tx_pin(ch1_tx_pin));
  unis_remote i_unis_remote (.clock(clock), .line_in(ch1_tx_pin),
    .line_out(ch1_rx_pin));

  // Clock of 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Timer rollover every third clock
  always @(negedge clock) begin
    tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
    timer_rollover <= (tcnt == 2'h2);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // One register write, strobe held for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : wr

  // Register read, data one edge after the address
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    sfr_addr = a;
    @(negedge clock);
    check({8'h00, sfr_rdata}, {8'h00, exp});
  endtask : rdchk

  // Reset values, reserved bits and unmapped addresses
  task automatic t_regs;
    rdchk(unis_pkg::UNIS_CTRL_ADDR, 8'h00); // control clear
    rdchk(unis_pkg::UNIS_IRCTL_ADDR, 8'h0F); // divisor fifteen
    rdchk(unis_pkg::UNIS_SERIAL_BUFFER_ADDR, 8'h00); // buffer clear
    check({15'h0, ch1_tx_pin}, 16'h1); // shaper off
    wr(8'h55, 8'hFF);
    rdchk(8'h55, 8'h00); // unmapped reads zero
    wr(unis_pkg::UNIS_CTRL_ADDR, 8'h14);
    rdchk(unis_pkg::UNIS_CTRL_ADDR, 8'h00); // read-only ninth bit
    wr(unis_pkg::UNIS_IRCTL_ADDR, 8'hFF);
    rdchk(unis_pkg::UNIS_IRCTL_ADDR, 8'h7F); // reserved bit
    check({15'h0, ch1_tx_pin}, 16'h0); // pin idles low
    wr(unis_pkg::UNIS_IRCTL_ADDR, 8'h0F);
    repeat (2) @(negedge clock);
    check({15'h0, ch1_tx_pin}, 16'h1); // direct path
    $display("register test done");
  endtask : t_regs

  // Frames sent at 1/32, 1/64 and both timer rates
  task automatic t_tx;
    logic [7:0] ctl [4] = '{8'h48, 8'h00, 8'hC8, 8'h80};
    int bc [4] = '{32, 64, 48, 96};
    logic [10:0] f;
    logic [7:0] d;
    int lat;
    for (int i = 0; i < 4; i++) begin
      d = 8'hA5 ^ 8'(i);
      wr(unis_pkg::UNIS_CTRL_ADDR, ctl[i]);
      wr(unis_pkg::UNIS_SERIAL_BUFFER_ADDR, d);
      i_unis_remote.recv(bc[i], f, lat);
      check({15'h0, lat <= bc[i] + 3}, 16'h1); // start latency
      check({5'h0, f}, {5'h0, 2'b10, d, 1'b0} | // frame
        {6'h0, ctl[i][3], 9'h0}); // ninth bit
      rdchk(unis_pkg::UNIS_CTRL_ADDR, ctl[i] | 8'h02); // done flag
    end
    $display("transmit test done");
  endtask : t_tx

  // Receive, flag and address filter, false start, noise
  task automatic t_rx;
    wr(unis_pkg::UNIS_CTRL_ADDR, 8'h40);
    i_unis_remote.send(32, 1'b0, 0, 1'b0, 9'h1C3);
    rdchk(unis_pkg::UNIS_SERIAL_BUFFER_ADDR, 8'hC3); // byte taken
    rdchk(unis_pkg::UNIS_CTRL_ADDR, 8'h45); // ninth bit and flag
    i_unis_remote.send(32, 1'b0, 0, 1'b0, 9'h012);
    rdchk(unis_pkg::UNIS_SERIAL_BUFFER_ADDR, 8'hC3); // flag blocks load
    wr(unis_pkg::UNIS_CTRL_ADDR, 8'h60);
    i_unis_remote.send(32, 1'b0, 0, 1'b0, 9'h055);
    i_unis_remote.send(32, 1'b0, 0, 1'b0, 9'h1AA);
    rdchk(unis_pkg::UNIS_SERIAL_BUFFER_ADDR, 8'hAA); // filtered frame
    rdchk(unis_pkg::UNIS_CTRL_ADDR, 8'h65); // flag set
    wr(unis_pkg::UNIS_CTRL_ADDR, 8'h40);
    i_unis_remote.false_start(3);
    repeat (40) @(negedge clock);
    i_unis_remote.send(32, 1'b0, 0, 1'b1, 9'h0F0);
    rdchk(unis_pkg::UNIS_SERIAL_BUFFER_ADDR, 8'hF0); // glitches ignored
    rdchk(unis_pkg::UNIS_CTRL_ADDR, 8'h41); // ninth bit zero
    $display("receive test done");
  endtask : t_rx

  // Shaped transmit pulses in both width modes
  task automatic t_ir_tx;
    logic [7:0] cfg [3] = '{8'h60, 8'h45, 8'h46};
    int wd [3] = '{12, 15, 18};
    int w;
    int n;
    wr(unis_pkg::UNIS_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(unis_pkg::UNIS_IRCTL_ADDR, cfg[i]);
      repeat (2) @(negedge clock);
      check({15'h0, ch1_tx_pin}, 16'h0); // no pulse when idle
      wr(unis_pkg::UNIS_SERIAL_BUFFER_ADDR, 8'h5A);
      i_unis_remote.ir_recv(704, w, n);
      check(16'(w), 16'(wd[i])); // pulse width
      check(16'(n), 16'h0006); // one pulse per zero
    end
    $display("shaper transmit test done");
  endtask : t_ir_tx

  // Shaped receive pulses stretched into bits
  task automatic t_ir_rx;
    wr(unis_pkg::UNIS_IRCTL_ADDR, 8'h60);
    i_unis_remote.idle(1'b0);
    repeat (700) @(negedge clock);
    wr(unis_pkg::UNIS_CTRL_ADDR, 8'h40);
    i_unis_remote.send(32, 1'b1, 6, 1'b0, 9'h13C);
    rdchk(unis_pkg::UNIS_SERIAL_BUFFER_ADDR, 8'h3C); // stretched bits
    rdchk(unis_pkg::UNIS_CTRL_ADDR, 8'h45); // ninth bit and flag
    $display("shaper receive test done");
  endtask : t_ir_rx

  // Watchdog at several times the expected run length
  initial begin
    #3000000;
    fails++;
    final_report;
  end

  // Reset, then the scenarios in order
  initial begin
    arst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    tcnt = 2'h0;
    timer_rollover = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (12) @(negedge clock);
    arst_n = 1'b1;
    t_regs;
    t_tx;
    t_rx;
    t_ir_tx;
    t_ir_rx;
    final_report;
  end
endmodule : tb
`default_nettype wire
